// ---- rps_pkg.sv ----
// Constants for the remappable output pin-select block.
// Assumes a 32-bit APB register bus with 12-bit byte addresses.
package rps_pkg;
  localparam int NUM_OUT = 12;
  localparam int NUM_G3 = 11;
  localparam int NUM_IN = 4;
  localparam int ST_W = 3;
  localparam int SHW = (NUM_OUT + NUM_IN) * 8;

  // Byte addresses, one aligned word each
  localparam logic [11:0] OUT_SEL_BASE = 12'h000;
  localparam logic [11:0] OUT_SEL_END = 12'h030;
  localparam logic [11:0] IN_SEL_BASE = 12'h030;
  localparam logic [11:0] IN_SEL_END = 12'h040;
  localparam logic [11:0] CTRL_ADDR = 12'h040;
  localparam logic [11:0] FUSE_ADDR = 12'h044;
  localparam logic [11:0] STATUS_ADDR = 12'h048;
  localparam logic [11:0] MASK_ADDR = 12'h04C;

  localparam int LOCK_BIT = 6;
  localparam int FUSE_BIT = 0;
  localparam logic [7:0] SEL_RESET = 8'h00;
  localparam logic LOCK_RESET = 1'b0;

  // Codes that select a real peripheral, one bit per code
  localparam logic [15:0] G2_VALID = 16'h67FE;
  localparam logic [15:0] G3_VALID = 16'h63FE;

  // Sticky status bits
  localparam int ST_MISMATCH = 0;
  localparam int ST_LOCKED_WR = 1;
  localparam int ST_UNLOCK_REFUSED = 2;
endpackage

// ---- rps_out_mux.sv ----
// One pin of the output crossbar: code to peripheral signal.
// Assumes code bit k of VALID marks a code with a real peripheral.
`timescale 1ns/1ns
module rps_out_mux #(
  parameter logic [15:0] VALID = 16'h0000
) (
  input wire logic [3:0] code_i,
  input wire logic [15:0] sig_i,
  output logic own_o,
  output logic data_o
);
  // Disabled, unused and reserved codes leave the pin to its port
  assign own_o = VALID[code_i];
  assign data_o = VALID[code_i] & sig_i[code_i];
endmodule

// ---- rps_shadow.sv ----
// Shadow copy of all mapping registers and its comparator.
// Assumes load_i marks every legitimate update with its new value.
`timescale 1ns/1ns
module rps_shadow import rps_pkg::*; #(
  parameter int W = SHW
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic load_i,
  input wire logic [W-1:0] next_i,
  input wire logic [W-1:0] live_i,
  output logic mismatch_o
);
  typedef struct packed {
    logic [W-1:0] copy;
  } rps_shadow_type;

  rps_shadow_type s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (load_i) begin
      s_d.copy = next_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Any change not made through a legal write shows up here
  assign mismatch_o = (s_q.copy != live_i);
endmodule

// ---- rps_pin_select.sv ----
// Remappable output pin-select crossbar with mapping lock and shadow check.
// Assumes an APB master, peripherals and pads on the same clock.
//
// Functional notes
// - Pins 4n+2 take their code from bits 3:0 of the shared select register.
// - Group 4n+2 codes 1 to A, D and E pick the listed peripheral outputs.
// - Input and output mapping of a two-way signal may name different pins.
// - No interlock between mapping registers; conflicts are stored as written.
// - Mapping registers are compared with a shadow; a mismatch raises reset.
// - With the one-way fuse set, a set lock bit cannot be cleared.
// - The fuse reads set when unprogrammed; cleared it allows relocking.
// - The lock bit is clear after reset.
`timescale 1ns/1ns
module rps_pin_select import rps_pkg::*; (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic pready_o,
  output logic [31:0] prdata_o,
  output logic pslverr_o,
  input wire logic [7:0] config_byte_5_high_i,
  input wire logic uart1_tx_clock_i,
  input wire logic uart2_rx_data_i,
  input wire logic uart3_baud_clock_i,
  input wire logic uart4_baud_clock_i,
  input wire logic spi2_serial_clock_i,
  input wire logic pwm1_output_b_i,
  input wire logic pwm2_output_b_i,
  input wire logic enh_ccp3_output_a_i,
  input wire logic capcmp6_output_i,
  input wire logic capcmp10_output_i,
  input wire logic virtual_pin_2_i,
  input wire logic virtual_pin_6_i,
  input wire logic uart1_rx_data_i,
  input wire logic uart2_tx_clock_i,
  input wire logic spi1_serial_clock_i,
  input wire logic enh_ccp1_output_a_i,
  input wire logic enh_ccp2_output_a_i,
  input wire logic pwm3_output_d_i,
  input wire logic modulator_output_i,
  input wire logic capcmp4_output_i,
  input wire logic comparator3_output_i,
  input wire logic virtual_pin_3_i,
  input wire logic virtual_pin_7_i,
  output logic [NUM_OUT-1:0] g2_pin_data_o,
  output logic [NUM_OUT-1:0] g2_pin_periph_o,
  output logic [NUM_G3-1:0] g3_pin_data_o,
  output logic [NUM_G3-1:0] g3_pin_periph_o,
  output logic [NUM_IN*8-1:0] in_sel_o,
  output logic mapping_lock_o,
  output logic cfg_mismatch_rst_o,
  output logic irq_o
);
  typedef struct packed {
    logic [NUM_OUT-1:0][7:0] out_sel;
    logic [NUM_IN-1:0][7:0] in_sel;
    logic lock;
    logic [ST_W-1:0] status;
    logic [ST_W-1:0] mask;
    logic [31:0] rdata;
    logic rerr;
    logic [NUM_OUT-1:0] g2_data;
    logic [NUM_OUT-1:0] g2_own;
    logic [NUM_G3-1:0] g3_data;
    logic [NUM_G3-1:0] g3_own;
    logic mism;
  } rps_state_type;

  rps_state_type s_q, s_d;

  logic [15:0] g2_sig, g3_sig;
  logic [NUM_OUT-1:0] g2_own, g2_data;
  logic [NUM_G3-1:0] g3_own, g3_data;
  logic fuse_one_way;
  logic wr_acc, map_load, mismatch;
  logic [ST_W-1:0] ev;
  logic [SHW-1:0] live_flat, next_flat;

  function automatic logic is_out(input logic [11:0] a);
    return (a[1:0] == 2'b00) && (a >= OUT_SEL_BASE) && (a < OUT_SEL_END);
  endfunction

  function automatic logic is_in(input logic [11:0] a);
    return (a[1:0] == 2'b00) && (a >= IN_SEL_BASE) && (a < IN_SEL_END);
  endfunction

  function automatic logic addr_ok(input logic [11:0] a);
    return is_out(a) || is_in(a) || a == CTRL_ADDR || a == FUSE_ADDR ||
      a == STATUS_ADDR || a == MASK_ADDR;
  endfunction

  function automatic logic [3:0] word_idx(input logic [11:0] a, input logic [11:0] base);
    logic [11:0] off;
    off = a - base;
    return off[5:2];
  endfunction

  // Peripheral outputs placed at the bit of their select code
  assign g2_sig = {1'b0, virtual_pin_6_i, virtual_pin_2_i, 2'b00, capcmp10_output_i,
    capcmp6_output_i, enh_ccp3_output_a_i, pwm2_output_b_i, pwm1_output_b_i,
    spi2_serial_clock_i, uart4_baud_clock_i, uart3_baud_clock_i, uart2_rx_data_i,
    uart1_tx_clock_i, 1'b0};
  assign g3_sig = {1'b0, virtual_pin_7_i, virtual_pin_3_i, 3'b000, comparator3_output_i,
    capcmp4_output_i, modulator_output_i, pwm3_output_d_i, enh_ccp2_output_a_i,
    enh_ccp1_output_a_i, spi1_serial_clock_i, uart2_tx_clock_i, uart1_rx_data_i,
    1'b0};

  for (genvar i = 0; i < NUM_OUT; i++) begin : g_g2
    rps_out_mux #(.VALID(G2_VALID)) u_mux (
      .code_i(s_q.out_sel[i][3:0]),
      .sig_i(g2_sig),
      .own_o(g2_own[i]),
      .data_o(g2_data[i])
    );
  end

  for (genvar i = 0; i < NUM_G3; i++) begin : g_g3
    rps_out_mux #(.VALID(G3_VALID)) u_mux (
      .code_i(s_q.out_sel[i][7:4]),
      .sig_i(g3_sig),
      .own_o(g3_own[i]),
      .data_o(g3_data[i])
    );
  end

  // Unprogrammed fuse reads as one: one lock session only
  assign fuse_one_way = config_byte_5_high_i[FUSE_BIT];
  assign wr_acc = psel_i && penable_i && pwrite_i && addr_ok(paddr_i);
  assign live_flat = {s_q.in_sel, s_q.out_sel};
  assign next_flat = {s_d.in_sel, s_d.out_sel};

  rps_shadow #(.W(SHW)) u_shadow (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .load_i(map_load),
    .next_i(next_flat),
    .live_i(live_flat),
    .mismatch_o(mismatch)
  );

  always_comb begin
    s_d = s_q;
    ev = '0;
    map_load = 1'b0;
    // Registered pin drive keeps glitches off the pads
    s_d.g2_data = g2_data;
    s_d.g2_own = g2_own;
    s_d.g3_data = g3_data;
    s_d.g3_own = g3_own;
    s_d.mism = mismatch;
    ev[ST_MISMATCH] = mismatch;
    if (psel_i && !penable_i) begin
      s_d.rerr = !addr_ok(paddr_i);
      s_d.rdata = '0;
      if (is_out(paddr_i)) begin
        s_d.rdata[7:0] = s_q.out_sel[word_idx(paddr_i, OUT_SEL_BASE)];
      end else if (is_in(paddr_i)) begin
        s_d.rdata[7:0] = s_q.in_sel[2'(word_idx(paddr_i, IN_SEL_BASE))];
      end else if (paddr_i == CTRL_ADDR) begin
        s_d.rdata[LOCK_BIT] = s_q.lock;
      end else if (paddr_i == FUSE_ADDR) begin
        s_d.rdata[7:0] = config_byte_5_high_i;
      end else if (paddr_i == STATUS_ADDR) begin
        s_d.rdata[ST_W-1:0] = s_q.status;
      end else if (paddr_i == MASK_ADDR) begin
        s_d.rdata[ST_W-1:0] = s_q.mask;
      end
    end
    if (wr_acc) begin
      if (is_out(paddr_i) || is_in(paddr_i)) begin
        if (s_q.lock) begin
          ev[ST_LOCKED_WR] = 1'b1;
        end else if (is_out(paddr_i)) begin
          // Stored as written, even if another pin has the same code
          s_d.out_sel[word_idx(paddr_i, OUT_SEL_BASE)] = pwdata_i[7:0];
          map_load = 1'b1;
        end else begin
          // Input side is independent of the output side
          s_d.in_sel[2'(word_idx(paddr_i, IN_SEL_BASE))] = pwdata_i[7:0];
          map_load = 1'b1;
        end
      end else if (paddr_i == CTRL_ADDR) begin
        if (s_q.lock && !pwdata_i[LOCK_BIT] && fuse_one_way) begin
          ev[ST_UNLOCK_REFUSED] = 1'b1;
        end else begin
          s_d.lock = pwdata_i[LOCK_BIT];
        end
      end else if (paddr_i == MASK_ADDR) begin
        s_d.mask = pwdata_i[ST_W-1:0];
      end
    end
    // Write one clears; a same-cycle event wins
    if (wr_acc && paddr_i == STATUS_ADDR) begin
      s_d.status = s_q.status & ~pwdata_i[ST_W-1:0];
    end
    s_d.status = s_d.status | ev;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s_q <= '0;
      s_q.out_sel <= {NUM_OUT{SEL_RESET}};
      s_q.in_sel <= {NUM_IN{SEL_RESET}};
      s_q.lock <= LOCK_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign pready_o = 1'b1;
  assign prdata_o = s_q.rdata;
  assign pslverr_o = psel_i && penable_i && s_q.rerr;
  assign g2_pin_data_o = s_q.g2_data;
  assign g2_pin_periph_o = s_q.g2_own;
  assign g3_pin_data_o = s_q.g3_data;
  assign g3_pin_periph_o = s_q.g3_own;
  assign in_sel_o = s_q.in_sel;
  assign mapping_lock_o = s_q.lock;
  assign cfg_mismatch_rst_o = s_q.mism;
  assign irq_o = |(s_q.status & s_q.mask);

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  property p_lock_blocks;
    s_q.lock && wr_acc && (is_out(paddr_i) || is_in(paddr_i)) |=>
      $stable(s_q.out_sel) && $stable(s_q.in_sel) && s_q.status[ST_LOCKED_WR];
  endproperty
  a_lock_blocks: assert property (p_lock_blocks)
    else $error("locked mapping write changed a register");

  property p_fuse_holds;
    mapping_lock_o && fuse_one_way && wr_acc && paddr_i == CTRL_ADDR |=>
      mapping_lock_o ##1 mapping_lock_o || wr_acc;
  endproperty
  a_fuse_holds: assert property (p_fuse_holds)
    else $error("lock cleared while one-way fuse set");

  property p_unlock_free;
    mapping_lock_o && !fuse_one_way && wr_acc && paddr_i == CTRL_ADDR &&
      !pwdata_i[LOCK_BIT] |=> !mapping_lock_o;
  endproperty
  a_unlock_free: assert property (p_unlock_free)
    else $error("lock not cleared with fuse programmed");

  property p_lock_reset;
    $fell(srst_i) |-> !mapping_lock_o;
  endproperty
  a_lock_reset: assert property (p_lock_reset)
    else $error("lock set after reset");

  property p_g2_map;
    ##1 g2_pin_periph_o[0] == G2_VALID[$past(s_q.out_sel[0][3:0])] &&
      g2_pin_data_o[NUM_OUT-1] == (G2_VALID[$past(s_q.out_sel[NUM_OUT-1][3:0])] &&
      $past(g2_sig[s_q.out_sel[NUM_OUT-1][3:0]]));
  endproperty
  a_g2_map: assert property (p_g2_map)
    else $error("4n+2 pin does not follow its code");

  property p_g3_map;
    ##1 g3_pin_periph_o[1] == G3_VALID[$past(s_q.out_sel[1][7:4])] &&
      g3_pin_data_o[1] == (G3_VALID[$past(s_q.out_sel[1][7:4])] &&
      $past(g3_sig[s_q.out_sel[1][7:4]]));
  endproperty
  a_g3_map: assert property (p_g3_map)
    else $error("4n+3 pin does not follow its code");

  property p_null_code;
    s_q.out_sel[2][3:0] inside {4'h0, 4'hB, 4'hC, 4'hF} |=>
      !g2_pin_periph_o[2] && !g2_pin_data_o[2];
  endproperty
  a_null_code: assert property (p_null_code)
    else $error("null code drove a peripheral output");

  property p_mismatch;
    mismatch |=> cfg_mismatch_rst_o && s_q.status[ST_MISMATCH];
  endproperty
  a_mismatch: assert property (p_mismatch)
    else $error("shadow mismatch did not raise reset");

  property p_map_write;
    !s_q.lock && wr_acc && is_in(paddr_i) |=>
      in_sel_o == $past(next_flat[SHW-1:NUM_OUT*8]) && !cfg_mismatch_rst_o;
  endproperty
  a_map_write: assert property (p_map_write)
    else $error("input mapping write not stored");

  c_locked_write: cover property (s_q.lock && wr_acc && is_out(paddr_i));
  c_unlock_refused: cover property (ev[ST_UNLOCK_REFUSED]);
  c_pin_owned: cover property (g2_pin_periph_o[0] ##1 g3_pin_periph_o[0]);
endmodule

// ---- rps_periph_model.sv ----
// Peripheral side: each peripheral output follows one pattern bit.
// Assumes pattern bit k stands for select code k of its group.
`timescale 1ns/1ns
module rps_periph_model (
  input wire logic [15:0] p2_i,
  input wire logic [15:0] p3_i,
  output logic [11:0] g2_o,
  output logic [10:0] g3_o
);
  // Unused and reserved codes have no source here
  assign g2_o = {p2_i[14:13], p2_i[10:1]};
  assign g3_o = {p3_i[14:13], p3_i[9:1]};
endmodule

// ---- rps_pin_select_test.sv ----
// Self-checking bench for the remappable output pin-select block.
// Assumes zero-wait APB and pin outputs registered one edge after their cause.
`timescale 1ns/1ns
module rps_pin_select_test;
  logic clk_i, srst_i, psel, penable, pwrite, pready, pslverr, err, lock, mis, irq;
  logic [11:0] paddr, s2, g2d, g2p;
  logic [31:0] pwdata, prdata, rd, in_sel;
  logic [7:0] cfg;
  logic [15:0] p2, p3;
  logic [10:0] s3, g3d, g3p;
  int n_errors = 0;
  int num_checks = 0;

  rps_periph_model u_rps_periph_model (.p2_i(p2), .p3_i(p3), .g2_o(s2), .g3_o(s3));

  rps_pin_select u_rps_pin_select (
    .clk_i(clk_i), .srst_i(srst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready),
    .prdata_o(prdata), .pslverr_o(pslverr), .config_byte_5_high_i(cfg),
    .uart1_tx_clock_i(s2[0]), .uart2_rx_data_i(s2[1]), .uart3_baud_clock_i(s2[2]),
    .uart4_baud_clock_i(s2[3]), .spi2_serial_clock_i(s2[4]), .pwm1_output_b_i(s2[5]),
    .pwm2_output_b_i(s2[6]), .enh_ccp3_output_a_i(s2[7]), .capcmp6_output_i(s2[8]),
    .capcmp10_output_i(s2[9]), .virtual_pin_2_i(s2[10]), .virtual_pin_6_i(s2[11]),
    .uart1_rx_data_i(s3[0]), .uart2_tx_clock_i(s3[1]), .spi1_serial_clock_i(s3[2]),
    .enh_ccp1_output_a_i(s3[3]), .enh_ccp2_output_a_i(s3[4]), .pwm3_output_d_i(s3[5]),
    .modulator_output_i(s3[6]), .capcmp4_output_i(s3[7]), .comparator3_output_i(s3[8]),
    .virtual_pin_3_i(s3[9]), .virtual_pin_7_i(s3[10]), .g2_pin_data_o(g2d),
    .g2_pin_periph_o(g2p), .g3_pin_data_o(g3d), .g3_pin_periph_o(g3p),
    .in_sel_o(in_sel), .mapping_lock_o(lock), .cfg_mismatch_rst_o(mis), .irq_o(irq)
  );

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Idle edge first so no signal is assigned twice in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      n_errors++;
      end_of_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input string name, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, '0);
    chk(name, rd, exp);
  endtask

  task automatic settle();
    @(posedge clk_i);
    @(negedge clk_i);
  endtask

  task automatic pat(input logic [15:0] v);
    @(posedge clk_i);
    p2 <= v;
    p3 <= v;
    settle();
  endtask

  task automatic do_reset();
    @(posedge clk_i);
    srst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    srst_i <= 1'b0;
  endtask

  task automatic t_reset();
    settle();
    chk("periph", {g3p, g2p}, '0);
    chk("lock", lock, '0);
    rdc("ctrl", 12'h040, '0);
    rdc("fuse", 12'h044, 32'h0000_0001);
    rdc("hole", 12'h050, '0);
    chk("slverr", err, 32'h0000_0001);
    $display("reset test done");
  endtask

  task automatic t_codes();
    logic [15:0] v2, v3, oh;
    int k;
    v2 = 16'h67FE;
    v3 = 16'h63FE;
    for (int j = 0; j < 2; j++) begin
      k = j * 11;
      for (int c = 0; c < 16; c++) begin
        oh = 16'h0001 << c;
        wr(12'(4 * k), {24'h00_0000, 4'(c), 4'(c)});
        pat(oh);
        chk("g2p", g2p, v2[c] ? 12'h001 << k : '0);
        chk("g2d", g2d, v2[c] ? 12'h001 << k : '0);
        chk("g3p", g3p, (v3[c] && k == 0) ? 11'h001 : '0);
        chk("g3d", g3d, (v3[c] && k == 0) ? 11'h001 : '0);
        pat(~oh);
        chk("g2d inv", g2d, '0);
        chk("g3d inv", g3d, '0);
      end
      rdc("sel", 12'(4 * k), 32'h0000_00FF);
      wr(12'(4 * k), '0);
    end
    $display("code test done");
  endtask

  task automatic t_conflict();
    wr(12'h000, 32'h0000_0011);
    wr(12'h004, 32'h0000_0011);
    wr(12'h030, 32'h0000_0005);
    wr(12'h034, 32'h0000_0002);
    pat(16'h0002);
    chk("dup g2", g2d, 32'h0000_0003);
    chk("dup g3", g3p, 32'h0000_0003);
    chk("in sel", in_sel, 32'h0000_0205);
    chk("mismatch", mis, '0);
    rdc("sel1", 12'h004, 32'h0000_0011);
    $display("conflict test done");
  endtask

  task automatic t_lock(input logic fuse);
    @(posedge clk_i);
    cfg <= {7'h00, fuse};
    wr(12'h04C, 32'h0000_0006);
    wr(12'h000, 32'h0000_0021);
    wr(12'h030, 32'h0000_0003);
    wr(12'h040, 32'h0000_0040);
    wr(12'h000, 32'h0000_0055);
    wr(12'h030, 32'h0000_0055);
    rdc("locked sel", 12'h000, 32'h0000_0021);
    rdc("locked in", 12'h030, 32'h0000_0003);
    rdc("status", 12'h048, 32'h0000_0002);
    chk("irq", irq, 32'h0000_0001);
    wr(12'h048, 32'h0000_0002);
    settle();
    chk("irq clr", irq, '0);
    wr(12'h040, '0);
    settle();
    chk("lock kept", lock, {31'h0, fuse});
    rdc("status2", 12'h048, fuse ? 32'h0000_0004 : '0);
    chk("irq2", irq, {31'h0, fuse});
    wr(12'h04C, '0);
    settle();
    chk("irq masked", irq, '0);
    wr(12'h000, 32'h0000_0055);
    rdc("sel after", 12'h000, fuse ? 32'h0000_0021 : 32'h0000_0055);
    wr(12'h040, 32'h0000_0040);
    wr(12'h040, '0);
    rdc("relock", 12'h040, fuse ? 32'h0000_0040 : '0);
    do_reset();
    $display("lock test done");
  endtask

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  initial begin
    srst_i = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    cfg = 8'h01;
    p2 = '0;
    p3 = '0;
    repeat (5) @(posedge clk_i);
    srst_i <= 1'b0;
    t_reset();
    t_codes();
    t_conflict();
    t_lock(1'b1);
    t_lock(1'b0);
    end_of_test();
  end
endmodule
